// ---- rtl/jts_tap_select.sv ----
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "jts_map.svh"

module jts_tap_select
   import jts_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        trst_pin,
   input  wire logic        tck_pin,
   input  wire logic        tms_pin,
   input  wire logic        tdi_pin,
   output logic             tdo_out,
   output logic             tdo_oe,
   input  wire logic        emulator_line_zero_in,
   output logic             emulator_line_zero_out,
   output logic             emulator_line_zero_oe,
   input  wire logic        emulator_line_one_in,
   output logic             emulator_line_one_out,
   output logic             emulator_line_one_oe,
   output logic             trst_internal_pulldown_en,
   output logic             line_zero_internal_pullup_en,
   output logic             line_one_internal_pullup_en,
   output logic             tdo_internal_pullup_en,
   output logic             tdi_internal_pullup_en,
   output logic             tck_internal_pullup_en,
   output logic             test_mode,
   output jts_tap_type      tap_select,
   output logic             bscan_tck_rise,
   output logic             bscan_tck_fall,
   output logic             emu_tck_rise,
   output logic             emu_tck_fall,
   output logic             tap_tms,
   output logic             tap_tdi,
   input  wire logic        bscan_tdo,
   input  wire logic        bscan_scanning,
   input  wire logic        emu_tdo,
   input  wire logic        emu_scanning,
   output logic             emu_line_zero_seen,
   output logic             emu_line_one_seen,
   input  wire logic        emu_line_zero_drive,
   input  wire logic        emu_line_zero_dir,
   input  wire logic        emu_line_one_drive,
   input  wire logic        emu_line_one_dir
);

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic [`JTS_PIN_COUNT-1:0] pin_raw;
   logic [`JTS_PIN_COUNT-1:0] pin_stable_reg;
   logic [`JTS_PIN_COUNT-1:0] pin_prev_reg;

   assign pin_raw = {emulator_line_one_in, emulator_line_zero_in, tdi_pin, tms_pin, tck_pin, trst_pin};

   genvar gi;
   generate
      for (gi = 0; gi < `JTS_PIN_COUNT; gi++) begin : g_sync
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
            end else begin
               s1_reg <= pin_raw[gi];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
            end
         end
         // a change counts once the second and third stages agree
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               pin_stable_reg[gi] <= 1'b0;
            end else if (s2_reg == s3_reg) begin
               pin_stable_reg[gi] <= s3_reg;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pin_prev_reg <= '0;
      end else begin
         pin_prev_reg <= pin_stable_reg;
      end
   end

   logic trst_s;
   logic trst_rise;
   logic tck_rise;
   logic tck_fall;

   assign trst_s    = pin_stable_reg[`JTS_PIN_TRST];
   assign trst_rise = trst_s & ~pin_prev_reg[`JTS_PIN_TRST];
   assign tck_rise  = pin_stable_reg[`JTS_PIN_TCK] & ~pin_prev_reg[`JTS_PIN_TCK];
   assign tck_fall  = ~pin_stable_reg[`JTS_PIN_TCK] & pin_prev_reg[`JTS_PIN_TCK];

   // ----------------------------------------------------------------------
   // test mode and tap selection
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         test_mode <= 1'b0;
      end else begin
         test_mode <= trst_s;
      end
   end

   // boundary scan until the first test reset pulse
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tap_select <= JTS_TAP_BSCAN;
      end else if (trst_rise) begin
         tap_select <= jts_tap_type'(pin_stable_reg[`JTS_PIN_LINE0]);
      end
   end

   // ----------------------------------------------------------------------
   // tck edge routing and tms/tdi sampling
   // ----------------------------------------------------------------------
   logic route_ok;

   assign route_ok       = test_mode & trst_s;
   assign bscan_tck_rise = route_ok & tck_rise & (tap_select == JTS_TAP_BSCAN);
   assign bscan_tck_fall = route_ok & tck_fall & (tap_select == JTS_TAP_BSCAN);
   assign emu_tck_rise   = route_ok & tck_rise & (tap_select == JTS_TAP_EMU);
   assign emu_tck_fall   = route_ok & tck_fall & (tap_select == JTS_TAP_EMU);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tap_tms <= 1'b1;
         tap_tdi <= 1'b1;
      end else if (route_ok && tck_rise) begin
         tap_tms <= pin_stable_reg[`JTS_PIN_TMS];
         tap_tdi <= pin_stable_reg[`JTS_PIN_TDI];
      end
   end

   // ----------------------------------------------------------------------
   // tdo driver
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tdo_out <= 1'b0;
         tdo_oe  <= 1'b0;
      end else if (!route_ok) begin
         tdo_oe  <= 1'b0;
      end else if (tck_fall) begin
         tdo_out <= (tap_select == JTS_TAP_EMU) ? emu_tdo : bscan_tdo;
         tdo_oe  <= (tap_select == JTS_TAP_EMU) ? emu_scanning : bscan_scanning;
      end
   end

   // ----------------------------------------------------------------------
   // emulator interrupt lines
   // ----------------------------------------------------------------------
   assign emu_line_zero_seen = pin_stable_reg[`JTS_PIN_LINE0];
   assign emu_line_one_seen  = pin_stable_reg[`JTS_PIN_LINE1];

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         emulator_line_zero_out <= 1'b0;
         emulator_line_zero_oe  <= 1'b0;
      end else begin
         // line zero stays an input while the selection is being strapped
         emulator_line_zero_out <= emu_line_zero_drive;
         emulator_line_zero_oe  <= route_ok & emu_line_zero_dir;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         emulator_line_one_out <= 1'b0;
         emulator_line_one_oe  <= 1'b0;
      end else begin
         emulator_line_one_out <= emu_line_one_drive;
         emulator_line_one_oe  <= route_ok & emu_line_one_dir;
      end
   end

   // ----------------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------------
   logic [`JTS_PI_WIDTH-1:0] pull_inhibit_reg;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pull_inhibit_reg <= `JTS_PI_WIDTH'(`JTS_PULL_INHIBIT_RST);
      end else if (reg_wr && reg_addr == `JTS_PULL_INHIBIT_OFS) begin
         pull_inhibit_reg <= reg_wdata[`JTS_PI_WIDTH-1:0];
      end
   end

   assign trst_internal_pulldown_en = ~pull_inhibit_reg[`JTS_PI_TRST_PD];
   assign line_zero_internal_pullup_en = ~pull_inhibit_reg[`JTS_PI_LINE0_PU];
   assign line_one_internal_pullup_en  = ~pull_inhibit_reg[`JTS_PI_LINE1_PU];
   assign tdo_internal_pullup_en    = ~pull_inhibit_reg[`JTS_PI_TDO_PU];
   assign tdi_internal_pullup_en    = ~pull_inhibit_reg[`JTS_PI_TDI_PU];
   assign tck_internal_pullup_en    = ~pull_inhibit_reg[`JTS_PI_TCK_PU];

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd && reg_addr == `JTS_PULL_INHIBIT_OFS) begin
         reg_rdata <= {{(16-`JTS_PI_WIDTH){1'b0}}, pull_inhibit_reg};
      end else if (reg_rd && reg_addr == `JTS_STATUS_OFS) begin
         reg_rdata <= {12'h000, emu_line_one_seen, emu_line_zero_seen, tap_select, test_mode};
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   a_trst_takes_control: assert property (trst_s |=> test_mode)
      else $error("test reset high did not enter test mode");
   a_func_tdo_quiet: assert property (!trst_s |=> !tdo_oe && !bscan_tck_rise && !emu_tck_rise)
      else $error("test pins active in functional mode");
   a_sel_capture: assert property (trst_rise
                                   |=> tap_select == jts_tap_type'($past(pin_stable_reg[`JTS_PIN_LINE0])))
      else $error("tap select not captured from line zero");
   a_sel_route: assert property ((bscan_tck_rise || bscan_tck_fall) |-> tap_select == JTS_TAP_BSCAN)
      else $error("boundary scan got edges while emulation selected");
   a_emu_route: assert property ((emu_tck_rise || emu_tck_fall) |-> tap_select == JTS_TAP_EMU)
      else $error("emulation tap got edges while boundary scan selected");
   a_line0_dir: assert property (emulator_line_zero_oe |-> $past(trst_s) && $past(emu_line_zero_dir))
      else $error("line zero driven outside test mode");
   a_line1_dir: assert property (emu_line_one_dir && route_ok |=> emulator_line_one_oe)
      else $error("line one not driven when emulation asks");
   a_pd_write: assert property (reg_wr && reg_addr == `JTS_PULL_INHIBIT_OFS
                                |=> trst_internal_pulldown_en == !$past(reg_wdata[`JTS_PI_TRST_PD]))
      else $error("pulldown enable does not follow write");
   a_pulls_reset: assert property ($rose(nrst) |-> trst_internal_pulldown_en && line_zero_internal_pullup_en
                                   && line_one_internal_pullup_en)
      else $error("pull resistors not enabled after reset");
   a_sel_hold: assert property (!trst_rise |=> $stable(tap_select))
      else $error("tap select changed without test reset edge");
   a_tdo_on_fall: assert property ($changed(tdo_out) |-> $past(tck_fall))
      else $error("tdo changed off a tck fall");
   a_tms_on_rise: assert property ($changed(tap_tms) |-> $past(tck_rise))
      else $error("tms sampled off a tck rise");

   c_emu_select: cover property (trst_rise && pin_stable_reg[`JTS_PIN_LINE0]);
   c_bscan_shift: cover property (bscan_tck_fall ##1 tdo_oe);
   c_emu_shift: cover property (emu_tck_fall ##1 tdo_oe);
   c_pd_off: cover property (!trst_internal_pulldown_en);

endmodule

// ---- pkg/jts_map.svh ----
`ifndef JTS_MAP_SVH
`define JTS_MAP_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define JTS_PULL_INHIBIT_OFS 16'h1C18
`define JTS_STATUS_OFS       16'h1C1C
`define JTS_PULL_INHIBIT_RST 16'h0000
// ----------------------------------------------------------------------
// pull inhibit fields: 1 disables the resistor
// ----------------------------------------------------------------------
`define JTS_PI_TRST_PD       0
`define JTS_PI_LINE0_PU      1
`define JTS_PI_LINE1_PU      2
`define JTS_PI_TDO_PU        3
`define JTS_PI_TDI_PU        4
`define JTS_PI_TCK_PU        5
`define JTS_PI_WIDTH         6
// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define JTS_ST_TEST_MODE     0
`define JTS_ST_TAP_SEL       1
`define JTS_ST_LINE0         2
`define JTS_ST_LINE1         3
// ----------------------------------------------------------------------
// synchronised pin slots
// ----------------------------------------------------------------------
`define JTS_PIN_TRST         0
`define JTS_PIN_TCK          1
`define JTS_PIN_TMS          2
`define JTS_PIN_TDI          3
`define JTS_PIN_LINE0        4
`define JTS_PIN_LINE1        5
`define JTS_PIN_COUNT        6
`endif

// ---- pkg/jts_pkg.sv ----
package jts_pkg;
   typedef enum logic {
      JTS_TAP_BSCAN,
      JTS_TAP_EMU
   } jts_tap_type;
endpackage

// ---- verif/jts_emulator_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// emulator pod: drives the test pins, tck stands still between frames
// ----------------------------------------------------------------------
module jts_emulator_model (
   output logic trst_pin,
   output logic tck_pin,
   output logic tms_pin,
   output logic tdi_pin,
   output logic strap
);
   initial begin
      trst_pin = 1'b0;
      tck_pin  = 1'b0;
      tms_pin  = 1'b1;
      tdi_pin  = 1'b1;
      strap    = 1'b1;
   end
   // test reset pulse, strap held across the rise, then released to pull-up
   task automatic test_reset(input logic sel);
      trst_pin = 1'b0;
      strap    = sel;
      #40 trst_pin = 1'b1;
      #40 strap = 1'b1;
   endtask
   task automatic set_strap(input logic v);
      strap = v;
      #40;
   endtask
   // one 88 ns tck period, tms and tdi changed while tck is low
   task automatic tck_cycle(input logic ms, input logic di);
      tms_pin = ms;
      tdi_pin = di;
      #24 tck_pin = 1'b1;
      #24 tck_pin = 1'b0;
      #40;
   endtask
endmodule

// ---- verif/jts_tap_select_tb.sv ----
`timescale 1ns/1ps
`include "jts_map.svh"
module jts_tap_select_tb
   import jts_pkg::*;
;
   logic clock, nrst, reg_wr, reg_rd, tdo_out, tdo_oe, test_mode, tap_tms, tap_tdi;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
   logic trst_pin, tck_pin, tms_pin, tdi_pin, strap;
   logic emulator_line_zero_out, emulator_line_zero_oe, emulator_line_one_out, emulator_line_one_oe;
   logic trst_internal_pulldown_en, line_zero_internal_pullup_en, line_one_internal_pullup_en;
   logic tdo_internal_pullup_en, tdi_internal_pullup_en, tck_internal_pullup_en;
   logic bscan_tck_rise, bscan_tck_fall, emu_tck_rise, emu_tck_fall, emu_line_zero_seen, emu_line_one_seen;
   logic bscan_tdo, bscan_scanning, emu_tdo, emu_scanning;
   logic emu_line_zero_drive, emu_line_zero_dir, emu_line_one_drive, emu_line_one_dir;
   jts_tap_type tap_select;
   int error_cnt = 0;
   int checked = 0;
   int n_bs = 0;
   int n_em = 0;
   int n_fl = 0;
   // line levels: design drive wins, else pod strap or pull-up
   wire logic emulator_line_zero_in = emulator_line_zero_oe ? emulator_line_zero_out : strap;
   wire logic emulator_line_one_in  = emulator_line_one_oe ? emulator_line_one_out : 1'b1;
   wire logic [5:0] pulls = {tck_internal_pullup_en, tdi_internal_pullup_en, tdo_internal_pullup_en,
                             line_one_internal_pullup_en, line_zero_internal_pullup_en, trst_internal_pulldown_en};
   logic [15:0] row_w [5] = '{16'h0001, 16'h0006, 16'h003F, 16'hFFC0, 16'h0000};
   logic [5:0]  row_e [5] = '{6'h3E, 6'h39, 6'h00, 6'h3F, 6'h3F};
   logic [15:0] row_r [5] = '{16'h0001, 16'h0006, 16'h003F, 16'h0000, 16'h0000};

   jts_emulator_model m (.trst_pin, .tck_pin, .tms_pin, .tdi_pin, .strap);
   jts_tap_select dut (.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .trst_pin, .tck_pin, .tms_pin, .tdi_pin, .tdo_out, .tdo_oe, .emulator_line_zero_in,
      .emulator_line_zero_out, .emulator_line_zero_oe, .emulator_line_one_in, .emulator_line_one_out,
      .emulator_line_one_oe, .trst_internal_pulldown_en, .line_zero_internal_pullup_en,
      .line_one_internal_pullup_en, .tdo_internal_pullup_en, .tdi_internal_pullup_en,
      .tck_internal_pullup_en, .test_mode, .tap_select, .bscan_tck_rise, .bscan_tck_fall,
      .emu_tck_rise, .emu_tck_fall, .tap_tms, .tap_tdi, .bscan_tdo, .bscan_scanning, .emu_tdo,
      .emu_scanning, .emu_line_zero_seen, .emu_line_one_seen, .emu_line_zero_drive,
      .emu_line_zero_dir, .emu_line_one_drive, .emu_line_one_dir);

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (bscan_tck_rise === 1'b1) n_bs++;
      if (emu_tck_rise === 1'b1) n_em++;
      if (bscan_tck_fall === 1'b1 || emu_tck_fall === 1'b1) n_fl++;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] w);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] r);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 r = reg_rdata;
   endtask
   task automatic end_of_test;
      $display("error_cnt %0d checked %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      end_of_test;
   end
   initial begin
      {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {bscan_tdo, bscan_scanning, emu_tdo, emu_scanning} = '0;
      {emu_line_zero_drive, emu_line_zero_dir, emu_line_one_drive, emu_line_one_dir} = '0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      #1 chk("pulls", 16'h003F, 16'(pulls));
      chk("tap_select", 16'(JTS_TAP_BSCAN), 16'(tap_select));
      // ----------------------------------------------------------------------
      // pull inhibit rows
      // ----------------------------------------------------------------------
      for (int i = 0; i < 5; i++) begin
         wr(`JTS_PULL_INHIBIT_OFS, row_w[i]);
         rd(`JTS_PULL_INHIBIT_OFS, d);
         chk("inhibit", row_r[i], d);
         chk("pulls", 16'(row_e[i]), 16'(pulls));
      end
      rd(16'h1C20, d);
      chk("unmapped", 16'h0000, d);
      @(posedge clock);
      // ----------------------------------------------------------------------
      // functional mode, then selection and scanning
      // ----------------------------------------------------------------------
      emu_line_zero_dir <= 1'b1;
      emu_line_one_dir <= 1'b1;
      m.tck_cycle(1'b0, 1'b0);
      chk("rises", 16'h0000, 16'(n_bs + n_em));
      chk("tap_tms", 16'h0001, 16'(tap_tms));
      chk("line_oe", 16'h0000, 16'({emulator_line_zero_oe, emulator_line_one_oe, tdo_oe}));
      @(posedge clock);
      emu_line_zero_dir <= 1'b0;
      emu_line_one_dir <= 1'b0;
      m.test_reset(1'b0);
      chk("test_mode", 16'h0001, 16'(test_mode));
      chk("tap_select", 16'(JTS_TAP_BSCAN), 16'(tap_select));
      rd(`JTS_STATUS_OFS, d);
      chk("status", 16'h0001, d & 16'h0003);
      m.tck_cycle(1'b0, 1'b0);
      chk("bs_rise", 16'h0001, 16'(n_bs));
      chk("em_rise", 16'h0000, 16'(n_em));
      chk("tap_tms", 16'h0000, 16'(tap_tms));
      m.set_strap(1'b0);
      m.set_strap(1'b1);
      chk("tap_hold", 16'(JTS_TAP_BSCAN), 16'(tap_select));
      m.test_reset(1'b1);
      chk("tap_select", 16'(JTS_TAP_EMU), 16'(tap_select));
      @(posedge clock);
      emu_tdo <= 1'b1;
      emu_scanning <= 1'b1;
      m.tck_cycle(1'b1, 1'b0);
      chk("em_rise", 16'h0001, 16'(n_em));
      chk("bs_rise", 16'h0001, 16'(n_bs));
      chk("tdo", 16'h0003, 16'({tdo_oe, tdo_out}));
      chk("tap_tdi", 16'h0000, 16'(tap_tdi));
      @(posedge clock);
      emu_scanning <= 1'b0;
      m.tck_cycle(1'b1, 1'b1);
      chk("tdo_oe", 16'h0000, 16'(tdo_oe));
      @(posedge clock);
      emu_line_zero_drive <= 1'b1;
      emu_line_zero_dir <= 1'b1;
      emu_line_one_dir <= 1'b1;
      repeat (8) @(posedge clock);
      #1 chk("line0", 16'h0007, 16'({emulator_line_zero_oe, emulator_line_zero_out, emu_line_zero_seen}));
      chk("line1", 16'h0004, 16'({emulator_line_one_oe, emulator_line_one_out, emu_line_one_seen}));
      chk("em_rise", 16'h0002, 16'(n_em));
      chk("falls", 16'h0003, 16'(n_fl));
      end_of_test;
   end
endmodule
